// File: dv/rtc_countdown_watchdog_bench.sv
// Self-checking bench for the countdown watchdog over its register bus
`timescale 1ns/10ps
`include "rtc_wdog_defs.vh"
module rtc_countdown_watchdog_bench;
  localparam [9:0] A_CTL = {`IDX_COUNTDOWN_CONTROL, 2'h0};
  localparam [9:0] A_STS = {`IDX_IRQ_STATUS, 2'h0};
  localparam [9:0] A_MSK = {`IDX_IRQ_MASK, 2'h0};
  localparam [9:0] A_PIN = {`IDX_PIN_CONTROL, 2'h0};
  localparam [9:0] A_BAD = 10'h3fc;
  logic aclk = 1'h0, aresetn = 1'h0, osc_tick = 1'h0, corr_add = 1'h0, corr_skip = 1'h0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire irq, irq_out_a, irq_out_b;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int err_count = 0;
  int checked = 0;

  rtc_countdown_watchdog u_rtc_countdown_watchdog (
    .aclk, .aresetn, .osc_tick, .corr_add, .corr_skip, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .irq_out_a,
    .irq_out_b
  );

  // 40 MHz clock
  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic tally_and_finish;
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait ran out
  task automatic tmo;
    err_count++;
    $display("wrong value at %0t: wait timed out", $time);
    tally_and_finish();
  endtask

  // Value comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Bus write of one byte, response code checked
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk({30'h0, s_axi_bresp}, {30'h0, e});
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
      n++;
      if (n > 50) tmo();
    end
  endtask

  // Bus read returning data and response
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tb;
    n = 0;
    tb = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tb) s_axi_rready <= 1'h0;
      n++;
      if (n > 50) tmo();
    end
  endtask

  // Read and compare, expecting an OKAY response
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, 32'h0);
  endtask

  // Cycles until pin A is seen high
  task automatic wt(output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 40000) tmo();
    end while (irq_out_a !== 1'h1);
  endtask

  // Main sequence
  initial begin
    int n;
    logic [31:0] d, e;
    logic [1:0] r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    osc_tick <= 1'h1;
    rdc(A_CTL, 32'h0);
    rdc(A_MSK, 32'h0);
    rdc(A_PIN, 32'h0);
    wr(A_BAD, 8'h1, 2'h2);
    rd(A_BAD, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    // Single shot, count 3, fastest step, pin A level
    wr(A_PIN, 8'h01, 2'h0);
    wr(A_CTL, 8'h0f, 2'h0);
    wt(n);
    chk(n >= 4080 && n <= 6160, 32'h1);
    rdc(A_CTL, 32'h03);
    rdc(A_STS, 32'h1);
    chk(irq, 32'h0);
    wr(A_MSK, 8'h1, 2'h0);
    @(negedge aclk);
    chk(irq, 32'h1);
    repeat (4200) @(posedge aclk);
    rdc(A_STS, 32'h1);
    rdc(A_CTL, 32'h03);
    wr(A_STS, 8'h1, 2'h0);
    rdc(A_STS, 32'h0);
    chk(irq, 32'h0);
    chk(irq_out_a, 32'h0);
    // Repeat mode, count 2, pulses on both pins, flag left set
    wr(A_PIN, 8'h0f, 2'h0);
    wr(A_CTL, 8'h8b, 2'h0);
    wt(n);
    wt(n);
    chk(n, 4096);
    wt(n);
    chk(n, 4096);
    chk(irq_out_b, 32'h1);
    @(negedge aclk);
    chk(irq_out_a, 32'h0);
    rdc(A_STS, 32'h1);
    // New count mid-period, then live read back
    wr(A_CTL, 8'hff, 2'h0);
    rd(A_CTL, d, r);
    chk(d[6:2] >= 5'h1e, 32'h1);
    repeat (2045) @(posedge aclk); // Captures exactly one step apart
    rd(A_CTL, e, r);
    chk({27'h0, e[6:2]}, {27'h0, d[6:2] - 5'h1});
    rd(A_CTL, d, r);
    chk(d[6:2] == e[6:2] || d[6:2] == e[6:2] - 5'h1, 32'h1);
    // Zero count stops the counter
    wr(A_CTL, 8'h03, 2'h0);
    wr(A_STS, 8'h1, 2'h0);
    repeat (6200) @(posedge aclk);
    rdc(A_STS, 32'h0);
    rdc(A_CTL, 32'h03);
    // Step rates with count 1 in repeat mode
    wr(A_CTL, 8'h86, 2'h0);
    wt(n);
    wt(n);
    chk(n, 8192);
    // Inserted ticks double the rate: 1 Hz step in 16384 cycles
    @(posedge aclk);
    corr_add <= 1'h1;
    wr(A_CTL, 8'h85, 2'h0);
    wt(n);
    wt(n);
    chk(n, 16384);
    @(posedge aclk);
    corr_add <= 1'h0;
    wr(A_CTL, 8'h87, 2'h0);
    wt(n);
    wt(n);
    chk(n, 2048);
    rdc(A_CTL, 32'h87);
    tally_and_finish();
  end
endmodule

// File: dv/wdog_asserts.sv
// Bus handshake and interrupt pin checks for the countdown watchdog
`timescale 1ns/10ps
module wdog_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq,
  input wire irq_out_a,
  input wire irq_out_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data taken at the same edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response one idle cycle later
  sequence resp_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_bresp_timing: assert property (wr_taken |=> resp_late)
    else $error("write response not two cycles after accept");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after accept");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed after data");
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !irq_out_a && !irq_out_b && !s_axi_bvalid)
    else $error("outputs active right after reset");
endmodule

bind rtc_countdown_watchdog wdog_asserts u_wdog_asserts (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .irq, .irq_out_a, .irq_out_b
);

// File: logic/axil_slave.v
// AXI4-Lite slave front end with one write and one read in flight
`timescale 1ns/10ps
`include "rtc_wdog_defs.vh"

module axil_slave #(
  parameter ADDR_WIDTH = `ADDR_WIDTH
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire wr_en,
  output reg [ADDR_WIDTH-1:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  output wire [ADDR_WIDTH-1:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_err
);

  // Write fires once both halves are held and no response is pending
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_addr = s_axi_araddr;

  // Write channels, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      wr_addr <= {ADDR_WIDTH{1'b0}};
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: data captured at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// File: logic/rtc_countdown_watchdog.v
// Countdown watchdog with AXI4-Lite registers and two interrupt pins
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "rtc_wdog_defs.vh"

module rtc_countdown_watchdog #(
  parameter ADDR_WIDTH = `ADDR_WIDTH,
  parameter COUNT_WIDTH = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire osc_tick,
  input wire corr_add,
  input wire corr_skip,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq,
  output reg irq_out_a,
  output reg irq_out_b
);

  localparam [ADDR_WIDTH-1:0] ADDR_CTRL = {`IDX_COUNTDOWN_CONTROL, 2'b00};
  localparam [ADDR_WIDTH-1:0] ADDR_STATUS = {`IDX_IRQ_STATUS, 2'b00};
  localparam [ADDR_WIDTH-1:0] ADDR_MASK = {`IDX_IRQ_MASK, 2'b00};
  localparam [ADDR_WIDTH-1:0] ADDR_PINS = {`IDX_PIN_CONTROL, 2'b00};
  localparam [7:0] RST_CTRL = `RST_COUNTDOWN_CONTROL;

  wire wr_en;
  wire [ADDR_WIDTH-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [ADDR_WIDTH-1:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_err;
  reg wr_err;
  wire step_pulse;

  reg wdog_repeat_sel;
  reg [1:0] wdog_step_sel;
  reg [COUNT_WIDTH-1:0] wdog_count_value;
  reg [COUNT_WIDTH-1:0] reload_value;
  reg [COUNT_WIDTH-1:0] load_value;
  reg load_pending;
  reg expire;
  reg wdog_expired_flag;
  reg irq_mask;
  reg wdog_irq_en_a;
  reg wdog_irq_en_b;
  reg pulse_mode_a;
  reg pulse_mode_b;

  wire wr_low_lane = wr_en && wr_strb[0];
  wire ctrl_write = wr_low_lane && (wr_addr == ADDR_CTRL);
  wire status_write = wr_low_lane && (wr_addr == ADDR_STATUS);
  wire mask_write = wr_low_lane && (wr_addr == ADDR_MASK);
  wire pins_write = wr_low_lane && (wr_addr == ADDR_PINS);

  // Bus front end
  axil_slave #(
    .ADDR_WIDTH(ADDR_WIDTH)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Step-rate generator from the corrected oscillator
  step_divider #(
    .DIV_WIDTH(`DIV_WIDTH)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_tick(osc_tick),
    .corr_add(corr_add),
    .corr_skip(corr_skip),
    .step_sel(wdog_step_sel),
    .step_pulse(step_pulse)
  );

  // Unmapped addresses answer SLVERR and read zero
  always @* begin
    wr_err = !((wr_addr == ADDR_CTRL) || (wr_addr == ADDR_STATUS) ||
               (wr_addr == ADDR_MASK) || (wr_addr == ADDR_PINS));
    rd_err = 1'b0;
    rd_data = 32'h00000000;
    case (rd_addr)
      ADDR_CTRL: begin
        rd_data[`FLD_REPEAT] = wdog_repeat_sel;
        rd_data[`FLD_COUNT_HI:`FLD_COUNT_LO] = wdog_count_value;
        rd_data[`FLD_STEP_HI:`FLD_STEP_LO] = wdog_step_sel;
      end
      ADDR_STATUS: begin
        rd_data[`FLD_EXPIRED] = wdog_expired_flag;
      end
      ADDR_MASK: begin
        rd_data[`FLD_EXPIRED] = irq_mask;
      end
      ADDR_PINS: begin
        rd_data[`FLD_EN_A] = wdog_irq_en_a;
        rd_data[`FLD_EN_B] = wdog_irq_en_b;
        rd_data[`FLD_PULSE_A] = pulse_mode_a;
        rd_data[`FLD_PULSE_B] = pulse_mode_b;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // Control fields; the count field goes to a load stage, not to storage
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdog_repeat_sel <= RST_CTRL[`FLD_REPEAT];
      wdog_step_sel <= `STEP_0P25HZ;
      load_value <= {COUNT_WIDTH{1'b0}};
      load_pending <= 1'b0;
    end else begin
      load_pending <= ctrl_write;
      if (ctrl_write) begin
        wdog_repeat_sel <= wr_data[`FLD_REPEAT];
        wdog_step_sel <= wr_data[`FLD_STEP_HI:`FLD_STEP_LO];
        load_value <= wr_data[`FLD_COUNT_HI:`FLD_COUNT_LO];
      end
    end
  end

  // Countdown: a load wins over a step; the divider runs free so the first
  // period after a load may be short by up to one step
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdog_count_value <= {COUNT_WIDTH{1'b0}};
      reload_value <= {COUNT_WIDTH{1'b0}};
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load_pending) begin
        wdog_count_value <= load_value;
        reload_value <= load_value;
      end else if (step_pulse && (wdog_count_value != {COUNT_WIDTH{1'b0}})) begin
        if (wdog_count_value == {{(COUNT_WIDTH-1){1'b0}}, 1'b1}) begin
          expire <= 1'b1;
          if (wdog_repeat_sel) begin
            wdog_count_value <= reload_value;
          end else begin
            wdog_count_value <= {COUNT_WIDTH{1'b0}};
          end
        end else begin
          wdog_count_value <= wdog_count_value - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Sticky flag: write one to clear, a same-cycle expiry wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdog_expired_flag <= 1'b0;
    end else if (expire) begin
      wdog_expired_flag <= 1'b1;
    end else if (status_write && wr_data[`FLD_EXPIRED]) begin
      wdog_expired_flag <= 1'b0;
    end
  end

  // Mask and pin control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= `RST_IRQ_MASK;
      {pulse_mode_b, pulse_mode_a, wdog_irq_en_b, wdog_irq_en_a} <= `RST_PIN_CONTROL;
    end else begin
      if (mask_write) begin
        irq_mask <= wr_data[`FLD_EXPIRED];
      end
      if (pins_write) begin
        wdog_irq_en_a <= wr_data[`FLD_EN_A];
        wdog_irq_en_b <= wr_data[`FLD_EN_B];
        pulse_mode_a <= wr_data[`FLD_PULSE_A];
        pulse_mode_b <= wr_data[`FLD_PULSE_B];
      end
    end
  end

  // Per-pin drive: pulse on every expiry, flag or not, else follow the flag
  wire [1:0] pin_en = {wdog_irq_en_b, wdog_irq_en_a};
  wire [1:0] pin_pulse = {pulse_mode_b, pulse_mode_a};
  wire [1:0] next_pin;
  genvar pin;
  generate
    for (pin = 0; pin < 2; pin = pin + 1) begin : g_pin
      assign next_pin[pin] = pin_en[pin] && (pin_pulse[pin] ? expire : wdog_expired_flag);
    end
  endgenerate

  // Interrupt outputs, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
    end else begin
      irq <= wdog_expired_flag && irq_mask;
      irq_out_a <= next_pin[0];
      irq_out_b <= next_pin[1];
    end
  end

endmodule

// File: logic/rtc_wdog_defs.vh
// Constants for the countdown watchdog: offsets, fields, resets, divider taps
`ifndef RTC_WDOG_DEFS_VH
`define RTC_WDOG_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_COUNTDOWN_CONTROL 8'h2d
`define IDX_IRQ_STATUS 8'h2e
`define IDX_IRQ_MASK 8'h2f
`define IDX_PIN_CONTROL 8'h30
`define ADDR_WIDTH 10

// Fields of countdown_control
`define FLD_REPEAT 7
`define FLD_COUNT_HI 6
`define FLD_COUNT_LO 2
`define FLD_STEP_HI 1
`define FLD_STEP_LO 0

// Fields of irq_status / irq_mask
`define FLD_EXPIRED 0

// Fields of pin_control
`define FLD_EN_A 0
`define FLD_EN_B 1
`define FLD_PULSE_A 2
`define FLD_PULSE_B 3

// Reset values
`define RST_COUNTDOWN_CONTROL 8'h00
`define RST_IRQ_MASK 1'b0
`define RST_PIN_CONTROL 4'h0

// Step selector codes
`define STEP_0P25HZ 2'b00
`define STEP_1HZ 2'b01
`define STEP_4HZ 2'b10
`define STEP_16HZ 2'b11

// Oscillator tick counter: bit k toggles every 2**k ticks of 32.768 kHz
`define OSC_HZ 32768
`define DIV_WIDTH 18
`define TAP_0P25HZ 17
`define TAP_1HZ 15
`define TAP_4HZ 13
`define TAP_16HZ 11

// AXI response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: logic/step_divider.v
// Step-rate divider from corrected oscillator ticks
`timescale 1ns/10ps
`include "rtc_wdog_defs.vh"

module step_divider #(
  parameter DIV_WIDTH = `DIV_WIDTH
) (
  input wire aclk,
  input wire aresetn,
  input wire osc_tick,
  input wire corr_add,
  input wire corr_skip,
  input wire [1:0] step_sel,
  output reg step_pulse
);

  reg [DIV_WIDTH-1:0] tick_count;
  reg [DIV_WIDTH-1:0] next_tick_count;
  reg [1:0] inc;
  reg tap_now;
  reg tap_next;

  // Net ticks after correction: add inserts, skip removes one tick
  always @* begin
    inc = {1'b0, osc_tick} + {1'b0, corr_add} - {1'b0, corr_skip};
    if (corr_skip && !osc_tick && !corr_add) begin
      inc = 2'b00;
    end
    next_tick_count = tick_count + {{(DIV_WIDTH-2){1'b0}}, inc};
    case (step_sel)
      `STEP_0P25HZ: begin
        tap_now = tick_count[`TAP_0P25HZ];
        tap_next = next_tick_count[`TAP_0P25HZ];
      end
      `STEP_1HZ: begin
        tap_now = tick_count[`TAP_1HZ];
        tap_next = next_tick_count[`TAP_1HZ];
      end
      `STEP_4HZ: begin
        tap_now = tick_count[`TAP_4HZ];
        tap_next = next_tick_count[`TAP_4HZ];
      end
      default: begin
        tap_now = tick_count[`TAP_16HZ];
        tap_next = next_tick_count[`TAP_16HZ];
      end
    endcase
  end

  // Free-running divider; a toggle of the selected tap is one step
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_count <= {DIV_WIDTH{1'b0}};
      step_pulse <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      step_pulse <= (tap_now != tap_next);
    end
  end

endmodule
